/* File: design/dps_power_switch_ctrl.sv */
// dual-slot card power switch control: serial port, switch decode, faults, apb
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dps_power_switch_ctrl (
  // system
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial control pins from the socket host
  input wire logic i_serial_data,
  input wire logic i_serial_clk,
  input wire logic i_serial_latch,
  // card reset pins
  input wire logic i_card_reset,
  input wire logic i_card_reset_n,
  // analog monitors
  input wire logic [3:0] i_overcurrent_sense,
  input wire logic i_over_temp,
  input wire logic i_below_ground,
  // switch drive and flags
  output logic [11:0] o_switch_closed,
  output logic [3:0] o_current_limit,
  output logic o_low_power,
  output logic o_overcurrent_flag_n,
  output logic o_latched_off,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [10:0] pins_s;
  logic data_s;
  logic clk_s;
  logic latch_s;
  logic card_rst_s;
  logic card_rst_n_s;
  logic [3:0] oc_s;
  logic temp_s;
  logic below_s;

  // every pin crosses two flops before any logic looks at it
  dps_sync #(
    .WIDTH(11)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_async({i_serial_data, i_serial_clk, i_serial_latch, i_card_reset,
              i_card_reset_n, i_overcurrent_sense, i_over_temp, i_below_ground}),
    .o_sync(pins_s)
  );

  // unpack the synchronised copies
  assign {data_s, clk_s, latch_s, card_rst_s, card_rst_n_s, oc_s, temp_s, below_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the link

  logic clk_prev_q;
  logic latch_prev_q;
  logic oc_any_prev_q;
  logic temp_prev_q;
  logic clk_rise;
  logic latch_rise;
  logic card_rst_any;

  // previous synchronised levels for edge finding
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_prev_q <= 1'b0;
      latch_prev_q <= 1'b0;
      oc_any_prev_q <= 1'b0;
      temp_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
      latch_prev_q <= latch_s;
      oc_any_prev_q <= |oc_s;
      temp_prev_q <= temp_s;
    end
  end

  // data and clock share the same delay, so data_s is aligned with clk_rise
  assign clk_rise = clk_s & ~clk_prev_q;
  assign latch_rise = latch_s & ~latch_prev_q;
  // either polarity of reset pin alone forces the grounded state
  assign card_rst_any = card_rst_s | ~card_rst_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // shift register and latched control word

  logic [8:0] shift_q;
  logic [8:0] word_q;
  logic [3:0] bitcnt_q;

  // newest bit enters at position 0, older bits move up toward D8
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_q <= dps_pkg::WORD_RST;
    end else if (clk_rise) begin
      shift_q <= {shift_q[7:0], data_s};
    end
  end

  // bits seen since the last latch, for software diagnosis of short frames
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bitcnt_q <= dps_pkg::BITCNT_RST;
    end else if (latch_rise) begin
      bitcnt_q <= dps_pkg::BITCNT_RST;
    end else if (clk_rise && bitcnt_q != dps_pkg::BITCNT_MAX) begin
      bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  // word changes only on the latch edge; shifting leaves switches alone
  // a latch in the same cycle as a clock edge takes the word before that bit
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_q <= dps_pkg::WORD_RST;
    end else if (latch_rise) begin
      word_q <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output state machine

  dps_pkg::dps_state_e state_q;

  // below-ground fault holds until the system reset, which stands for power
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= dps_pkg::ST_GROUNDED;
    end else begin
      case (state_q)
        dps_pkg::ST_GROUNDED: begin
          if (below_s) begin
            state_q <= dps_pkg::ST_FAULT_OFF;
          end else if (latch_rise && !card_rst_any) begin
            state_q <= dps_pkg::ST_ACTIVE;
          end
        end
        dps_pkg::ST_ACTIVE: begin
          if (below_s) begin
            state_q <= dps_pkg::ST_FAULT_OFF;
          end else if (card_rst_any) begin
            state_q <= dps_pkg::ST_GROUNDED;
          end
        end
        dps_pkg::ST_FAULT_OFF: begin
          state_q <= dps_pkg::ST_FAULT_OFF;
        end
        default: begin
          state_q <= dps_pkg::ST_GROUNDED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch decode per slot

  dps_pkg::dps_mode_e slot_mode;
  logic power_down;
  logic [11:0] sw_d;
  logic [3:0] sel_bits [2];

  assign power_down = ~word_q[dps_pkg::POS_POWER_DOWN];

  // thermal and below-ground win over the reset ground, as opening is safest
  always_comb begin
    if (state_q == dps_pkg::ST_FAULT_OFF || temp_s) begin
      slot_mode = dps_pkg::MODE_OPEN;
    end else if (state_q != dps_pkg::ST_ACTIVE || card_rst_any) begin
      slot_mode = dps_pkg::MODE_GROUND;
    end else if (power_down) begin
      slot_mode = dps_pkg::MODE_OPEN;
    end else begin
      slot_mode = dps_pkg::MODE_RUN;
    end
  end

  // per-slot bits: supply hi, supply lo, prog high, prog supply
  assign sel_bits[0] = {word_q[dps_pkg::POS_A_SUPPLY_HI], word_q[dps_pkg::POS_A_SUPPLY_LO],
                        word_q[dps_pkg::POS_A_PROG_HIGH], word_q[dps_pkg::POS_A_PROG_SUPPLY]};
  assign sel_bits[1] = {word_q[dps_pkg::POS_B_SUPPLY_HI], word_q[dps_pkg::POS_B_SUPPLY_LO],
                        word_q[dps_pkg::POS_B_PROG_HIGH], word_q[dps_pkg::POS_B_PROG_SUPPLY]};

  // slot A supply S1..S3 and prog S7..S9; slot B supply S4..S6 and prog S10..S12
  for (genvar s = 0; s < dps_pkg::SLOT_N; s++) begin : g_slot
    dps_slot_decode u_decode (
      .i_mode(slot_mode),
      .i_supply_sel_hi(sel_bits[s][3]),
      .i_supply_sel_lo(sel_bits[s][2]),
      .i_prog_high_select(sel_bits[s][1]),
      .i_prog_supply_select(sel_bits[s][0]),
      .o_supply_sw(sw_d[3*s +: 3]),
      .o_prog_sw(sw_d[6 + 3*s +: 3])
    );
  end

  // overcurrent never opens a switch, so the decode ignores the sense lines
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_switch_closed <= dps_pkg::SW_RST;
    end else begin
      o_switch_closed <= sw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection flags

  // limiting acts on the affected output alone; the others keep their switches
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_current_limit <= 4'h0;
    end else begin
      o_current_limit <= oc_s;
    end
  end

  // flag is the nor of all four outputs, high while none of them limits
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_overcurrent_flag_n <= 1'b1;
    end else begin
      o_overcurrent_flag_n <= ~|oc_s;
    end
  end

  // low-current mode only while a latched word is in force, never while grounded
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_low_power <= 1'b0;
    end else begin
      o_low_power <= (state_q == dps_pkg::ST_ACTIVE) && !card_rst_any && power_down;
    end
  end

  // latched-off report lags the state by one edge, in step with the switches
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_latched_off <= 1'b0;
    end else begin
      o_latched_off <= (state_q == dps_pkg::ST_FAULT_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and interrupt

  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic [3:0] status_set;
  logic [3:0] status_clr;
  logic setup_ph;
  logic access_ph;
  logic hit;
  logic [31:0] rdata_d;
  logic fault_enter;

  assign setup_ph = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  // zero wait states: every access completes at its first access edge
  assign o_pready = 1'b1;
  assign fault_enter = below_s && state_q != dps_pkg::ST_FAULT_OFF;

  // address decode and read mux, sampled in the setup cycle
  always_comb begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (i_paddr)
      dps_pkg::OFF_WORD: rdata_d = {22'h0, state_q == dps_pkg::ST_ACTIVE, word_q};
      dps_pkg::OFF_SHIFT: rdata_d = {19'h0, bitcnt_q, shift_q};
      dps_pkg::OFF_STATUS: rdata_d = {28'h0, status_q};
      dps_pkg::OFF_MASK: rdata_d = {28'h0, mask_q};
      dps_pkg::OFF_FAULT: rdata_d = {22'h0, state_q, below_s, temp_s,
                                     card_rst_any, o_low_power, oc_s};
      default: hit = 1'b0;
    endcase
  end

  // read data registered in setup, stable through the access cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // error uses the same timing, so the master takes both at one edge
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pslverr <= 1'b0;
    end else if (setup_ph) begin
      o_pslverr <= ~hit;
    end
  end

  // mask steers the interrupt output
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_q <= dps_pkg::MASK_RST;
    end else if (access_ph && i_pwrite && i_paddr == dps_pkg::OFF_MASK) begin
      mask_q <= i_pwdata[dps_pkg::STAT_W-1:0];
    end
  end

  // events that set sticky status bits
  always_comb begin
    status_set = 4'h0;
    status_set[dps_pkg::STAT_LATCHED] = latch_rise;
    status_set[dps_pkg::STAT_OVERCURRENT] = (|oc_s) & ~oc_any_prev_q;
    status_set[dps_pkg::STAT_THERMAL] = temp_s & ~temp_prev_q;
    status_set[dps_pkg::STAT_FAULT_OFF] = fault_enter;
  end

  // a read clears only what it returned, so an event after setup survives
  assign status_clr = (access_ph && !i_pwrite && i_paddr == dps_pkg::OFF_STATUS) ?
                      o_prdata[dps_pkg::STAT_W-1:0] : 4'h0;

  // set wins over clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_q <= dps_pkg::STAT_RST;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // level interrupt from registered status and mask
  assign o_irq = |(status_q & mask_q);

endmodule // dps_power_switch_ctrl

/* File: inc/dps_pkg.sv */
// package: constants, field layout and types of the dual-slot power switch control
// How it works
// - host puts one bit per link clock period; each rising link edge samples it
// - rising latch edge copies the nine shifted bits D0..D8 into the control word
// - power-down bit D8 at 0 opens every switch and enters low-current operation
// - slot A prog (D0,D1): 00 ground, 01 card supply, 10 12 V, 11 open
// - slot B prog (D4,D5): 00 ground, 01 card supply, 10 12 V, 11 open
// - slot A supply (D3,D2): 00 ground, 01 3.3 V, 10 5 V, 11 ground
// - slot B supply (D6,D7): 00 ground, 01 3.3 V, 10 5 V, 11 ground
// - either reset input closes only the four ground switches
// - after reset outputs stay grounded until a fresh word is latched
// - two reset inputs, one active high, one active low, either one suffices
// - overcurrent flag is high normally, low while any output is overcurrent
// - overcurrent is per output; only that output limits, others keep state
// - current limiting never opens a switch; only thermal limiting does
// - over-temperature opens all outputs of both slots until it clears
// - an output driven below ground latches everything off until power cycles
package dps_pkg;
  // control word layout
  localparam int WORD_W = 9;
  localparam int POS_A_PROG_HIGH = 0;
  localparam int POS_A_PROG_SUPPLY = 1;
  localparam int POS_A_SUPPLY_LO = 2;
  localparam int POS_A_SUPPLY_HI = 3;
  localparam int POS_B_PROG_HIGH = 4;
  localparam int POS_B_PROG_SUPPLY = 5;
  localparam int POS_B_SUPPLY_HI = 6;
  localparam int POS_B_SUPPLY_LO = 7;
  localparam int POS_POWER_DOWN = 8;
  localparam logic [8:0] WORD_RST = 9'h000;
  localparam logic [3:0] BITCNT_RST = 4'h0;
  localparam logic [3:0] BITCNT_MAX = 4'hF;
  // switches: index n-1 drives switch n; each group of three is ground, mid, high
  localparam int SW_N = 12;
  localparam int GRP_GND = 0;
  localparam int GRP_MID = 1;
  localparam int GRP_HIGH = 2;
  localparam logic [11:0] SW_RST = 12'h000;
  // monitored outputs: 0 slot A supply, 1 slot A prog, 2 slot B supply, 3 slot B prog
  localparam int OUT_N = 4;
  localparam int SLOT_N = 2;
  // apb map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_WORD = 8'h00;
  localparam logic [7:0] OFF_SHIFT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_FAULT = 8'h10;
  // status bits, sticky, cleared by reading
  localparam int STAT_LATCHED = 0;
  localparam int STAT_OVERCURRENT = 1;
  localparam int STAT_THERMAL = 2;
  localparam int STAT_FAULT_OFF = 3;
  localparam int STAT_W = 4;
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // pin synchroniser depth
  localparam int SYNC_STAGES = 2;
  // output state of the whole device
  typedef enum logic [1:0] {ST_GROUNDED, ST_ACTIVE, ST_FAULT_OFF} dps_state_e;
  // what one slot does with its switches
  typedef enum logic [1:0] {MODE_GROUND, MODE_OPEN, MODE_RUN} dps_mode_e;
endpackage

/* File: design/dps_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dps_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // pins and their synchronised copies
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // dps_sync

/* File: design/dps_slot_decode.sv */
// switch selection of one slot from its four control bits and its mode
`timescale 1ns/1ps
module dps_slot_decode (
  // mode and control bits
  input wire dps_pkg::dps_mode_e i_mode,
  input wire logic i_supply_sel_hi,
  input wire logic i_supply_sel_lo,
  input wire logic i_prog_high_select,
  input wire logic i_prog_supply_select,
  // switch closures: ground, mid, high
  output logic [2:0] o_supply_sw,
  output logic [2:0] o_prog_sw
);
  // only one switch of a group is ever closed, so no supply meets another
  always_comb begin
    o_supply_sw = '0;
    o_prog_sw = '0;
    case (i_mode)
      dps_pkg::MODE_GROUND: begin
        o_supply_sw[dps_pkg::GRP_GND] = 1'b1;
        o_prog_sw[dps_pkg::GRP_GND] = 1'b1;
      end
      dps_pkg::MODE_RUN: begin
        case ({i_supply_sel_hi, i_supply_sel_lo})
          2'h1: o_supply_sw[dps_pkg::GRP_MID] = 1'b1;
          2'h2: o_supply_sw[dps_pkg::GRP_HIGH] = 1'b1;
          default: o_supply_sw[dps_pkg::GRP_GND] = 1'b1;
        endcase
        case ({i_prog_high_select, i_prog_supply_select})
          2'h0: o_prog_sw[dps_pkg::GRP_GND] = 1'b1;
          2'h1: o_prog_sw[dps_pkg::GRP_MID] = 1'b1;
          2'h2: o_prog_sw[dps_pkg::GRP_HIGH] = 1'b1;
          default: o_prog_sw = '0;
        endcase
      end
      default: begin
        o_supply_sw = '0;
        o_prog_sw = '0;
      end
    endcase
  end
endmodule // dps_slot_decode

/* File: verification/dps_power_switch_ctrl_props.sv */
// checker: switch, flag and fault relations at the top ports of the power switch control
`timescale 1ns/1ps
module dps_power_switch_ctrl_props (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // pins watched
  input wire logic i_serial_latch,
  input wire logic i_card_reset,
  input wire logic i_card_reset_n,
  input wire logic i_over_temp,
  input wire logic i_below_ground,
  // outputs watched
  input wire logic [11:0] o_switch_closed,
  input wire logic [3:0] o_current_limit,
  input wire logic o_low_power,
  input wire logic o_overcurrent_flag_n,
  input wire logic o_latched_off
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // both card resets idle long enough to pass the pin synchronisers
  sequence s_cards_idle;
    (!i_card_reset && i_card_reset_n)[*4];
  endsequence
  // nothing but shifting may happen in this window
  sequence s_quiet;
    (!i_serial_latch && !i_card_reset && i_card_reset_n && !i_over_temp && !i_below_ground)[*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  flag_tracks_oc_a: assert property (
    o_overcurrent_flag_n == !(|o_current_limit)) else $error("flag disagrees with limits");
  thermal_opens_a: assert property (
    i_over_temp[*4] |-> o_switch_closed == 12'h000) else $error("switch closed while hot");
  latched_holds_a: assert property (
    o_latched_off |=> o_latched_off) else $error("latched off state left without reset");
  latched_open_a: assert property (
    o_latched_off && $past(o_latched_off) |-> o_switch_closed == 12'h000)
    else $error("switch closed while latched off");
  power_down_open_a: assert property (
    s_cards_idle ##0 (o_low_power && $past(o_low_power)) |-> o_switch_closed == 12'h000)
    else $error("switch closed in power down");
  reset_high_gnd_a: assert property (
    (i_card_reset && !i_over_temp && !i_below_ground && !o_latched_off)[*5]
    |-> o_switch_closed == 12'h249) else $error("high reset not grounding");
  reset_low_gnd_a: assert property (
    (!i_card_reset_n && !i_over_temp && !i_below_ground && !o_latched_off)[*5]
    |-> o_switch_closed == 12'h249) else $error("low reset not grounding");
  shift_holds_a: assert property (
    s_quiet |-> $stable(o_switch_closed)) else $error("switches moved without a latch");
  decode_single_a: assert property (
    $onehot0(o_switch_closed[2:0]) && $onehot0(o_switch_closed[5:3])
    && $onehot0(o_switch_closed[8:6]) && $onehot0(o_switch_closed[11:9]))
    else $error("two switches of one output closed");
endmodule // dps_power_switch_ctrl_props

bind dps_power_switch_ctrl dps_power_switch_ctrl_props u_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_serial_latch(i_serial_latch),
  .i_card_reset(i_card_reset), .i_card_reset_n(i_card_reset_n), .i_over_temp(i_over_temp),
  .i_below_ground(i_below_ground), .o_switch_closed(o_switch_closed),
  .o_current_limit(o_current_limit), .o_low_power(o_low_power),
  .o_overcurrent_flag_n(o_overcurrent_flag_n), .o_latched_off(o_latched_off));

/* File: verification/dps_host_model.sv */
// partner: socket host driving the three serial control pins
`timescale 1ns/1ps
module dps_host_model (
  // serial pins towards the device
  output logic o_data,
  output logic o_clk,
  output logic o_latch
);
  // link clock stands low between frames
  initial begin
    o_data = 1'b0;
    o_clk = 1'b0;
    o_latch = 1'b0;
  end
  // odd offset keeps the link out of phase with the system clock
  task automatic send(input logic [8:0] w, input bit do_latch);
    #13;
    for (int i = 8; i >= 0; i--) begin
      o_data = w[i];
      #160 o_clk = 1'b1;
      #160 o_clk = 1'b0;
    end
    if (do_latch) begin
      #80 o_latch = 1'b1;
      #160 o_latch = 1'b0;
    end
    // released data line must not look like the last bit
    o_data = ~o_data;
  endtask
endmodule // dps_host_model

/* File: verification/dps_power_switch_ctrl_bench.sv */
// testbench: serial words, faults, resets and apb access of the power switch control
`timescale 1ns/1ps
module dps_power_switch_ctrl_bench;
  // design inputs, all valued at time zero
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_card_reset = 1'b0;
  logic i_card_reset_n = 1'b1;
  logic [3:0] i_overcurrent_sense = 4'h0;
  logic i_over_temp = 1'b0;
  logic i_below_ground = 1'b0;
  // host pins and design outputs
  logic i_serial_data, i_serial_clk, i_serial_latch;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_low_power, o_overcurrent_flag_n, o_latched_off, o_irq;
  logic [11:0] o_switch_closed;
  logic [3:0] o_current_limit;
  // bench state
  int failures = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic err;
  logic [8:0] w;
  logic [8:0] cur = 9'h1A6;

  dps_host_model host (.o_data(i_serial_data), .o_clk(i_serial_clk), .o_latch(i_serial_latch));
  dps_power_switch_ctrl uut (.i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_serial_data, .i_serial_clk, .i_serial_latch,
    .i_card_reset, .i_card_reset_n, .i_overcurrent_sense, .i_over_temp, .i_below_ground,
    .o_switch_closed, .o_current_limit, .o_low_power, .o_overcurrent_flag_n, .o_latched_off,
    .o_irq);

  // 25 MHz system clock
  always #20 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  // switch pattern for a latched word, from the selection tables
  function automatic logic [11:0] exp_sw(input logic [8:0] v);
    logic [11:0] s;
    s = 12'h000;
    if (v[8]) begin
      s[0] = v[3] == v[2];
      s[1] = !v[3] && v[2];
      s[2] = v[3] && !v[2];
      s[3] = v[6] == v[7];
      s[4] = !v[6] && v[7];
      s[5] = v[6] && !v[7];
      s[6] = !v[0] && !v[1];
      s[7] = !v[0] && v[1];
      s[8] = v[0] && !v[1];
      s[9] = !v[4] && !v[5];
      s[10] = !v[4] && v[5];
      s[11] = v[4] && !v[5];
    end
    return s;
  endfunction
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an access edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // bounded wait for a switch pattern
  task wait_sw(input logic [11:0] e);
    int n;
    n = 0;
    while (o_switch_closed !== e && n < 40) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (o_switch_closed !== e) begin
      failures++;
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    wait_sw(12'h249);
    check(o_switch_closed, 12'h249);
    host.send(9'h1A5, 1'b0);
    repeat (10) @(posedge i_clk_sys);
    check(o_switch_closed, 12'h249);
    $display("test reset and shift done");
    // every code of every field; first word also flushes the unlatched bits
    for (int c = 0; c < 4; c++) begin
      w = {1'b1, c[0], c[1], c[0], c[1], c[1], c[0], c[0], c[1]};
      host.send(w, 1'b1);
      wait_sw(exp_sw(w));
      check(o_switch_closed, exp_sw(w));
      apb(1'b0, 8'h00, 32'h0);
      check(rd & 32'h1FF, {23'h0, w});
      check(err, 1'b0);
    end
    host.send(9'h0FF, 1'b1);
    wait_sw(12'h000);
    check(o_switch_closed, 12'h000);
    check(o_low_power, 1'b1);
    host.send(cur, 1'b1);
    wait_sw(exp_sw(cur));
    check(o_switch_closed, exp_sw(cur));
    $display("test decode done");
    // overcurrent on one output, with its interrupt unmasked
    apb(1'b0, 8'h08, 32'h0);
    check(o_irq, 1'b0);
    apb(1'b1, 8'h0C, 32'h2);
    i_overcurrent_sense <= 4'b0100;
    repeat (6) @(posedge i_clk_sys);
    check(o_overcurrent_flag_n, 1'b0);
    check(o_current_limit, 4'b0100);
    check(o_switch_closed, exp_sw(cur));
    check(o_irq, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(rd[1], 1'b1);
    repeat (2) @(posedge i_clk_sys);
    check(o_irq, 1'b0);
    i_overcurrent_sense <= 4'h0;
    repeat (6) @(posedge i_clk_sys);
    check(o_overcurrent_flag_n, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    $display("test overcurrent and apb done");
    // thermal limit opens all, then restores
    i_over_temp <= 1'b1;
    wait_sw(12'h000);
    check(o_switch_closed, 12'h000);
    i_over_temp <= 1'b0;
    wait_sw(exp_sw(cur));
    check(o_switch_closed, exp_sw(cur));
    // each reset pin alone grounds until a new latch
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk_sys);
      i_card_reset <= (k == 0);
      i_card_reset_n <= (k == 0);
      wait_sw(12'h249);
      check(o_switch_closed, 12'h249);
      // hold the reset pin long enough for the grounding checks to engage
      repeat (3) @(posedge i_clk_sys);
      check(o_switch_closed, 12'h249);
      i_card_reset <= 1'b0;
      i_card_reset_n <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      check(o_switch_closed, 12'h249);
      host.send(cur, 1'b1);
      wait_sw(exp_sw(cur));
      check(o_switch_closed, exp_sw(cur));
    end
    $display("test thermal and card reset done");
    // below ground latches off until the supply is cycled
    @(posedge i_clk_sys);
    i_below_ground <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_below_ground <= 1'b0;
    check(o_latched_off, 1'b1);
    host.send(cur, 1'b1);
    repeat (10) @(posedge i_clk_sys);
    check(o_switch_closed, 12'h000);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    wait_sw(12'h249);
    check(o_latched_off, 1'b0);
    check(o_switch_closed, 12'h249);
    $display("test latched off done");
    wrap_up();
  end
endmodule // dps_power_switch_ctrl_bench
